// ---- rtl/desel_top.sv ----
// event flags, combiners and interrupt selector in front of the dsp core
`timescale 1ns/1ns
`include "desel_cfg.svh"
module desel_top #(
  parameter int NUM_EVT = `DESEL_NUM_EVT,
  parameter int NUM_PROG = `DESEL_NUM_PROG,
  parameter int SEL_W = `DESEL_SEL_W
) (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  // peripheral event sources
  input wire logic [NUM_EVT-1:0] EVT_IN,
  input wire logic [`DESEL_GPIO_N-1:0] GPIO_POL_IN,
  // event flag and combiner control
  input wire logic [NUM_EVT-1:0] EVT_CLR_IN,
  input wire logic [NUM_EVT-1:0] EVT_MASK_IN,
  input wire logic [NUM_EVT-1:0] EXC_MASK_IN,
  // interrupt selector control and cpu acknowledge
  input wire logic [NUM_PROG*SEL_W-1:0] INT_SEL_IN,
  input wire logic [NUM_PROG-1:0] INT_ACK_IN,
  // cpu interrupt lines and status
  output logic [`DESEL_NUM_CPU-1:0] CPU_INT_OUT,
  output logic [NUM_EVT-1:0] EVT_FLAG_OUT,
  output logic DROP_EVT_OUT
);

  generate
    if (NUM_EVT != `DESEL_NUM_EVT || NUM_PROG != `DESEL_NUM_PROG ||
        SEL_W != `DESEL_SEL_W)
    begin : g_bad_cfg
      $error("event, line or selector width differs from fixed map");
    end
  endgenerate

  logic rst_s1_q;
  logic rst_n;
  desel_pkg::desel_evt_t ev;
  desel_pkg::desel_evt_t ev_prev_q;
  desel_pkg::desel_evt_t ev_rise;
  desel_pkg::desel_evt_t evt_flag_q;
  desel_pkg::desel_evt_t evt_flag_d;
  desel_pkg::desel_evt_t cmb_en;
  desel_pkg::desel_evt_t exc_en;
  logic [`DESEL_NUM_GRP-1:0] comb_q;
  logic [`DESEL_NUM_GRP-1:0] comb_d;
  logic exc_d;
  desel_pkg::desel_prog_t hit_w;
  desel_pkg::desel_prog_t drop_w;
  desel_pkg::desel_prog_t pend_q;
  desel_pkg::desel_prog_t pend_d;
  desel_pkg::desel_cpu_t int_q;
  desel_pkg::desel_cpu_t int_d;
  logic drop_q;
  logic drop_d;

  // reset released through two flops so release is clean on MCLK_IN
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // the event map is hard wired: combiners take 0..3, drop takes 96
  genvar g;
  generate
    for (g = 0; g < NUM_EVT; g = g + 1)
    begin : g_evt
      if (g < `DESEL_NUM_GRP)
      begin : g_comb
        assign ev[g] = comb_q[g];
        assign cmb_en[g] = 1'b0;
        assign exc_en[g] = 1'b0;
      end
      else if (g == `DESEL_EVT_DROP)
      begin : g_drop
        assign ev[g] = drop_q;
        assign cmb_en[g] = ~EVT_MASK_IN[g];
        assign exc_en[g] = ~EXC_MASK_IN[g];
      end
      else if (g >= `DESEL_GPIO_LO && g < `DESEL_GPIO_LO + `DESEL_GPIO_N)
      begin : g_gpio
        // polarity bit 1 makes the falling edge of the pin the event
        assign ev[g] = EVT_IN[g] ^ GPIO_POL_IN[g-`DESEL_GPIO_LO];
        assign cmb_en[g] = ~EVT_MASK_IN[g];
        assign exc_en[g] = ~EXC_MASK_IN[g];
      end
      else
      begin : g_plain
        assign ev[g] = EVT_IN[g];
        assign cmb_en[g] = ~EVT_MASK_IN[g];
        assign exc_en[g] = ~EXC_MASK_IN[g];
      end
    end
  endgenerate

  assign ev_rise = ev & ~ev_prev_q;
  // a new event in the clearing cycle survives the clear
  assign evt_flag_d = (evt_flag_q & ~EVT_CLR_IN) | ev_rise;

  // combined events exclude 0..3 so a combiner cannot feed itself
  generate
    for (g = 0; g < `DESEL_NUM_GRP; g = g + 1)
    begin : g_grp
      assign comb_d[g] = |(evt_flag_q[g*`DESEL_GRP_W +: `DESEL_GRP_W] &
                           cmb_en[g*`DESEL_GRP_W +: `DESEL_GRP_W]);
    end
  endgenerate

  assign exc_d = |(evt_flag_q & exc_en);

  // selector: each programmable line watches the edge of one event
  generate
    for (g = 0; g < NUM_PROG; g = g + 1)
    begin : g_sel
      wire [SEL_W-1:0] sel = INT_SEL_IN[g*SEL_W +: SEL_W];
      assign hit_w[g] = ev_rise[sel];
      // an edge while the line is still pending cannot be delivered
      assign drop_w[g] = hit_w[g] & pend_q[g] & ~INT_ACK_IN[g];
    end
  endgenerate

  assign pend_q = int_q[`DESEL_NUM_CPU-1:`DESEL_FIRST_PROG];
  assign pend_d = (pend_q & ~INT_ACK_IN) | hit_w;
  assign drop_d = |drop_w;

  assign int_d[`DESEL_LINE_RST] = 1'b0;
  assign int_d[`DESEL_LINE_NMI] = 1'b0;
  assign int_d[`DESEL_LINE_EXC] = exc_d;
  assign int_d[`DESEL_LINE_SPARE] = 1'b0;
  assign int_d[`DESEL_NUM_CPU-1:`DESEL_FIRST_PROG] = pend_d;

  // reset line stays high while the selector itself is in reset
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_q <= 16'h0001;
      ev_prev_q <= '0;
      evt_flag_q <= '0;
      comb_q <= 4'h0;
      drop_q <= 1'b0;
    end
    else
    begin
      int_q <= int_d;
      ev_prev_q <= ev;
      evt_flag_q <= evt_flag_d;
      comb_q <= comb_d;
      drop_q <= drop_d;
    end
  end

  assign CPU_INT_OUT = int_q;
  assign EVT_FLAG_OUT = evt_flag_q;
  assign DROP_EVT_OUT = drop_q;

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!rst_n);

  property p_spare_line;
    !CPU_INT_OUT[`DESEL_LINE_SPARE];
  endproperty
  a_spare_line: assert property (p_spare_line)
    else $error("spare cpu line asserted");

  property p_rst_line;
    $past(rst_n) |-> !CPU_INT_OUT[`DESEL_LINE_RST];
  endproperty
  a_rst_line: assert property (p_rst_line)
    else $error("reset line high after reset release");

  property p_select;
    (|hit_w) |=>
      ((CPU_INT_OUT[15:4] & $past(hit_w)) == $past(hit_w));
  endproperty
  a_select: assert property (p_select)
    else $error("selected event did not raise its cpu line");

  property p_exc_line;
    ((evt_flag_q & exc_en) == '0) |=> !CPU_INT_OUT[`DESEL_LINE_EXC];
  endproperty
  a_exc_line: assert property (p_exc_line)
    else $error("exception line without unmasked flag");

  property p_nmi_line;
    !CPU_INT_OUT[`DESEL_LINE_NMI];
  endproperty
  a_nmi_line: assert property (p_nmi_line)
    else $error("nmi line asserted");

  property p_gpio_pol;
    $rose(EVT_IN[64] ^ GPIO_POL_IN[0]) |=> EVT_FLAG_OUT[64];
  endproperty
  a_gpio_pol: assert property (p_gpio_pol)
    else $error("gpio event missed under its polarity");

  property p_fixed_evt;
    $rose(EVT_IN[`DESEL_FIXED_EVT]) |=> EVT_FLAG_OUT[`DESEL_FIXED_EVT];
  endproperty
  a_fixed_evt: assert property (p_fixed_evt)
    else $error("fixed event not flagged at its number");

  // a drop on the heels of another gives no new edge on event 96
  property p_drop_evt;
    (|drop_w) |=> DROP_EVT_OUT ##1
      ($past(DROP_EVT_OUT, 2) || EVT_FLAG_OUT[`DESEL_EVT_DROP]);
  endproperty
  a_drop_evt: assert property (p_drop_evt)
    else $error("dropped interrupt did not raise event 96");

  property p_drop_cause;
    DROP_EVT_OUT |-> $past(drop_d);
  endproperty
  a_drop_cause: assert property (p_drop_cause)
    else $error("drop event without a dropped interrupt");

  property p_comb_hold;
    (|(evt_flag_q[127:32] & cmb_en[127:32])) |=> (|comb_q[3:1]);
  endproperty
  a_comb_hold: assert property (p_comb_hold)
    else $error("combiner low with unmasked flag pending");

  property p_comb_clear;
    ((evt_flag_q[63:32] & cmb_en[63:32]) == '0) |=> !comb_q[1];
  endproperty
  a_comb_clear: assert property (p_comb_clear)
    else $error("combiner high with no unmasked flag");

endmodule : desel_top

// ---- rtl/desel_cfg.svh ----
// constants of the dsp event interrupt selector
// How it works
// - sixteen cpu interrupt lines, some unused
// - reset, nmi, exception lines fixed, unselected
// - any of 128 events routes to twelve
// - all fifteen interrupt signals drive the cpu
// - nmi line never asserts on this device
// - only gpio events have programmable polarity
// - event numbering fixed; only mapping programmable
// - dropped cpu interrupt raises event 96
`ifndef DESEL_CFG_SVH
`define DESEL_CFG_SVH
`define DESEL_NUM_EVT 128
`define DESEL_NUM_CPU 16
`define DESEL_NUM_PROG 12
`define DESEL_FIRST_PROG 4
`define DESEL_SEL_W 7
`define DESEL_GRP_W 32
`define DESEL_NUM_GRP 4
`define DESEL_EVT_DROP 96
`define DESEL_GPIO_LO 64
`define DESEL_GPIO_N 15
`define DESEL_LINE_RST 0
`define DESEL_LINE_NMI 1
`define DESEL_LINE_EXC 2
`define DESEL_LINE_SPARE 3
`define DESEL_FIXED_EVT 20
`endif

// ---- rtl/desel_pkg.sv ----
// types shared by the dsp event interrupt selector
`include "desel_cfg.svh"
package desel_pkg;
  typedef logic [`DESEL_NUM_EVT-1:0] desel_evt_t;
  typedef logic [`DESEL_NUM_CPU-1:0] desel_cpu_t;
  typedef logic [`DESEL_NUM_PROG-1:0] desel_prog_t;
  typedef logic [`DESEL_SEL_W-1:0] desel_sel_t;
endpackage : desel_pkg

// ---- bench/desel_cpu_model.sv ----
// core-side model that acknowledges pending interrupt lines
`timescale 1ns/1ns
module desel_cpu_model (
  // clock and core lines
  input wire logic clk_in,
  input wire logic [15:0] cpu_int_in,
  input wire logic stall_in,
  // acknowledge to the selector
  output logic [11:0] ack_out
);
  initial ack_out = 12'h000;
  // stall models a busy core, so lines stay pending and can overflow
  always @(posedge clk_in)
    ack_out <= stall_in ? 12'h000 : cpu_int_in[15:4] & ~ack_out;
endmodule : desel_cpu_model

// ---- bench/test_desel_top.sv ----
// self-checking bench for the dsp event interrupt selector
`timescale 1ns/1ns
module test_desel_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stall = 1'b0;
  logic [127:0] evt = 128'h0, clr = 128'h0;
  logic [127:0] emask = {128{1'b1}}, xmask = {128{1'b1}};
  logic [14:0] pol = 15'h0;
  logic [83:0] sel = {12{7'h7f}};
  logic [11:0] ack, rise;
  logic [15:0] cpu, prev = 16'h0;
  logic [127:0] flag;
  logic drop;
  int errors = 0, tests_run = 0, drops = 0, e, k;
  logic [11:0] exp_q[$];
  always #50 clk = ~clk;
  desel_top dut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .EVT_IN(evt),
    .GPIO_POL_IN(pol), .EVT_CLR_IN(clr), .EVT_MASK_IN(emask),
    .EXC_MASK_IN(xmask), .INT_SEL_IN(sel), .INT_ACK_IN(ack),
    .CPU_INT_OUT(cpu), .EVT_FLAG_OUT(flag), .DROP_EVT_OUT(drop));
  desel_cpu_model core (.clk_in(clk), .cpu_int_in(cpu),
    .stall_in(stall), .ack_out(ack));
  task automatic chk(input string nm, input logic [15:0] ex,
    input logic [15:0] got);
    tests_run++;
    if (got !== ex)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic hit(input int ev);
    tick(1);
    evt[ev] = 1'b1;
    tick(1);
    evt[ev] = 1'b0;
    tick(2);
  endtask : hit
  // set wins over clear, so clear only while no source is rising
  task automatic wipe;
    clr = {128{1'b1}};
    tick(1);
    clr = 128'h0;
    tick(2);
  endtask : wipe
  // each newly raised line is matched against the oldest note
  always @(posedge clk)
  begin
    #1;
    rise = cpu[15:4] & ~prev[15:4];
    if (rst_n === 1'b1 && rise !== 12'h000)
      chk("rise", {4'h0, exp_q.size() > 0 ? exp_q.pop_front() : 12'hfff},
        {4'h0, rise});
    if (drop === 1'b1)
      drops++;
    prev = cpu;
  end
  initial
  begin
    #100000;
    errors++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'h32fbcdf8));
    tick(6);
    chk("reset", 16'h0001, cpu);
    tick(1);
    rst_n = 1'b1;
    tick(4);
    chk("idle", 16'h0000, cpu);
    for (int i = 0; i < 12; i++)
    begin
      e = 4 + $urandom % 60;
      sel[7*i +: 7] = 7'(e);
      exp_q.push_back(12'h001 << i);
      hit(e);
      chk("flag", 16'h0001, 16'(flag[e]));
      sel[7*i +: 7] = 7'h7f;
      wipe();
    end
    chk("queue", 16'h0000, 16'(exp_q.size()));
    chk("no drop", 16'h0000, 16'(drops));
    hit(20);
    chk("flag20", 16'h0001, 16'(flag[20]));
    wipe();
    $display("routing test done");
    stall = 1'b1;
    sel[6:0] = 7'h1e;
    exp_q.push_back(12'h001);
    hit(30);
    hit(30);
    tick(2);
    chk("drop", 16'h0001, 16'(drops));
    chk("flag96", 16'h0001, 16'(flag[96]));
    stall = 1'b0;
    tick(3);
    chk("acked", 16'h0000, cpu);
    sel[6:0] = 7'h7f;
    wipe();
    $display("drop test done");
    // a random gpio line first, then line 0 which the polarity check watches
    for (int j = 0; j < 2; j++)
    begin
      k = (j == 0) ? $urandom % 15 : 0;
      evt[64+k] = 1'b1;
      tick(2);
      pol[k] = 1'b1;
      wipe();
      chk("gpio hold", 16'h0000, 16'(flag[64+k]));
      evt[64+k] = 1'b0;
      tick(3);
      chk("gpio fall", 16'h0001, 16'(flag[64+k]));
      pol[k] = 1'b0;
      wipe();
    end
    $display("gpio test done");
    e = 32 + $urandom % 32;
    hit(e);
    xmask[e] = 1'b0;
    emask[e] = 1'b0;
    tick(3);
    chk("exc", 16'h0004, cpu);
    chk("comb", 16'h0001, 16'(flag[1]));
    wipe();
    tick(2);
    chk("exc off", 16'h0000, cpu);
    $display("combiner test done");
    close_out();
  end
endmodule : test_desel_top
